// ---- rtl/tvd_params.svh ----
`ifndef TVD_PARAMS_SVH
`define TVD_PARAMS_SVH
// ----------------------------------------
// widths and levels
// ----------------------------------------
`define TVD_CODE_W      8
`define TVD_LEVEL_W     10
// number of register stages from pin to output level
`define TVD_PIPE_STAGES 2
// pedestal in output lsbs, sized so white (no sync) is 0x133
`define TVD_PEDESTAL    10'h034
// sync step is four tenths of full-scale white, 0x133*4/10
`define TVD_SYNC_STEP   10'h07b
// synchroniser depth for pin inputs
`define TVD_SYNC_FF     3
`endif

// ---- rtl/tvd_pkg.sv ----
package tvd_pkg;
  typedef logic [7:0] tvd_code_t;
  typedef logic [9:0] tvd_level_t;
  typedef struct packed {
    tvd_code_t red;
    tvd_code_t green;
    tvd_code_t blue;
    logic      sync_n;
    logic      blank_n;
  } tvd_pixel_s;
endpackage

// ---- rtl/tvd_stream_if.sv ----
`timescale 1ns/1ps
interface tvd_stream_if;
  import tvd_pkg::*;
  tvd_pixel_s data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport dst (input data, input valid, output ready);
endinterface

// ---- rtl/tvd_skid_buf.sv ----
`timescale 1ns/1ps
module tvd_skid_buf (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  tvd_stream_if.dst in_s,
  tvd_stream_if.src out_s
);
  import tvd_pkg::*;
  // ----------------------------------------
  // two-entry buffer
  // ----------------------------------------
  tvd_pixel_s mem [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  wire        do_push = in_s.valid && in_s.ready && ce;
  wire        do_pop  = out_s.valid && out_s.ready && ce;
  assign in_s.ready  = (count != 2'h2);
  assign out_s.valid = (count != 2'h0);
  assign out_s.data  = mem[rd_ptr];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (do_push) wr_ptr <= ~wr_ptr;
      if (do_pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end
  // data array holds no reset; occupancy guards its use
  always_ff @(posedge clk) begin
    if (do_push) mem[wr_ptr] <= in_s.data;
  end
endmodule // tvd_skid_buf

// ---- rtl/tvd_dac_front.sv ----
// Behaviour
// - capture rgb codes on rising clock edges with ce high and the buffer not full
// - output follows capture after pipeline delay
// - sync and blank registered with pixels
// - latency taken as two aligned stages
// - blank low forces blanking level
// - blank high adds code to pedestal
// - blank low drops code and pedestal
// - sync high adds step to green
// - sync low removes green sync step
// - three 10-bit channels, sync step on green only
`timescale 1ns/1ps
`include "tvd_params.svh"
module tvd_dac_front (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire tvd_pkg::tvd_code_t red_code_in,
  input  wire tvd_pkg::tvd_code_t green_code_in,
  input  wire tvd_pkg::tvd_code_t blue_code_in,
  input  wire logic               sync_n_in,
  input  wire logic               blank_n_in,
  input  wire logic               out_ready,
  output logic                    out_valid,
  output tvd_pkg::tvd_level_t     red_current_out,
  output tvd_pkg::tvd_level_t     green_current_out,
  output tvd_pkg::tvd_level_t     blue_current_out,
  output logic                    sync_current_out,
  output logic                    in_stall
);
  import tvd_pkg::*;

  // ----------------------------------------
  // carriers between capture, buffer and output
  // ----------------------------------------
  tvd_stream_if cap_s ();
  tvd_stream_if buf_s ();

  // ----------------------------------------
  // input capture
  // ----------------------------------------
  // pixel pins come from the driving controller on this same clock, so no synchroniser.
  // the buffer entries are the input registers: a pin word is written into the
  // buffer at the capture edge, which keeps the pin-to-output path at two stages
  tvd_pixel_s pin_word;

  assign pin_word.red     = red_code_in;
  assign pin_word.green   = green_code_in;
  assign pin_word.blue    = blue_code_in;
  assign pin_word.sync_n  = sync_n_in;
  assign pin_word.blank_n = blank_n_in;

  assign cap_s.data = pin_word;

  // the controller streams with no valid of its own: every enabled edge is a pixel
  assign cap_s.valid = 1'b1;

  // ----------------------------------------
  // two-entry buffer
  // ----------------------------------------
  // a full buffer refuses the pin word of that edge; the output word never tears
  tvd_skid_buf u_buf (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .in_s  (cap_s.dst),
    .out_s (buf_s.src)
  );

  // ----------------------------------------
  // handshake decode
  // ----------------------------------------
  wire out_free  = !out_valid || out_ready;
  wire out_take  = ce && buf_s.valid && out_free;
  wire out_drain = ce && out_valid && out_ready && !out_take;
  wire cap_full  = !cap_s.ready;

  assign buf_s.ready = ce && out_free;

  // ----------------------------------------
  // buffered word fields
  // ----------------------------------------
  tvd_pixel_s px;
  tvd_code_t  codes [3];
  tvd_level_t lvl   [3];

  assign px = buf_s.data;

  wire blank_gate = px.blank_n;
  wire sync_gate  = px.sync_n;

  assign codes[0] = px.red;
  assign codes[1] = px.green;
  assign codes[2] = px.blue;

  // ----------------------------------------
  // level computation
  // ----------------------------------------
  // level = blank * (pedestal + code) + sync * step, the step on green only
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      localparam bit IS_GREEN = (gi == 1);
      wire tvd_level_t code_ext = {2'h0, codes[gi]};
      wire tvd_level_t ped      = blank_gate ? `TVD_PEDESTAL : 10'h000;
      wire tvd_level_t video    = blank_gate ? (ped + code_ext) : 10'h000;
      // red and blue never see sync current, so sync is a don't-care there
      wire tvd_level_t sync     = (IS_GREEN && sync_gate) ? `TVD_SYNC_STEP : 10'h000;
      assign lvl[gi] = video + sync;
    end
  endgenerate

  // ----------------------------------------
  // output valid
  // ----------------------------------------
  // second stage: buffer entry plus output register gives two-clock latency when flowing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else if (out_take) begin
      out_valid <= 1'b1;
    end else if (out_drain) begin
      out_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // red level
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      red_current_out <= 10'h000;
    end else if (out_take) begin
      red_current_out <= lvl[0];
    end
  end

  // ----------------------------------------
  // green level
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      green_current_out <= 10'h000;
    end else if (out_take) begin
      green_current_out <= lvl[1];
    end
  end

  // ----------------------------------------
  // blue level
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blue_current_out <= 10'h000;
    end else if (out_take) begin
      blue_current_out <= lvl[2];
    end
  end

  // ----------------------------------------
  // sync current switch
  // ----------------------------------------
  // travels with its own pixel word, so the switch lines up with the green step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_current_out <= 1'b0;
    end else if (out_take) begin
      sync_current_out <= sync_gate;
    end
  end

  // ----------------------------------------
  // stall flag
  // ----------------------------------------
  // registered, so it trails the refused edge by one clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_stall <= 1'b0;
    end else if (ce) begin
      in_stall <= cap_full;
    end
  end

endmodule // tvd_dac_front

// ---- test/tvd_dac_front_assertions.sv ----
`timescale 1ns/1ps
module tvd_chk (
  input wire logic                clk, rst, ce, out_ready, out_valid, sync_current_out, in_stall,
  input wire tvd_pkg::tvd_level_t red_current_out, green_current_out, blue_current_out
);
  import tvd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // green with its sync step taken off
  wire [9:0] gs = green_current_out - (sync_current_out ? 10'h07b : 10'h0);
  sequence s_stall; out_valid && !out_ready && ce; endsequence
  property p_rst; disable iff (1'b0) rst |-> !out_valid && red_current_out == 0 && green_current_out == 0; endproperty
  property p_red; red_current_out == 0 || red_current_out inside {[10'h034:10'h133]}; endproperty
  property p_blue; blue_current_out == 0 || blue_current_out inside {[10'h034:10'h133]}; endproperty
  property p_green; gs == 0 || gs inside {[10'h034:10'h133]}; endproperty
  property p_rb; (red_current_out == 0) == (blue_current_out == 0) && (red_current_out == 0) == (gs == 0); endproperty
  property p_hold; s_stall |=> out_valid && $stable({red_current_out, green_current_out, sync_current_out}); endproperty
  property p_full; s_stall [*4] |-> ##[0:1] in_stall; endproperty
  property p_ce; !ce |=> $stable({out_valid, blue_current_out, in_stall}); endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  a_red: assert property (p_red) else $error("red level out of range");
  a_blue: assert property (p_blue) else $error("blue level out of range");
  a_green: assert property (p_green) else $error("green level out of range");
  a_rb: assert property (p_rb) else $error("channels disagree on blanking");
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  a_full: assert property (p_full) else $error("no stall flag");
  a_ce: assert property (p_ce) else $error("state moved with ce low");
endmodule // tvd_chk
bind tvd_dac_front tvd_chk u_chk (.clk, .rst, .ce, .out_ready, .out_valid, .sync_current_out, .in_stall,
  .red_current_out, .green_current_out, .blue_current_out);

// ---- test/tvd_pix_src.sv ----
`timescale 1ns/1ps
module tvd_pix_src (
  input wire logic          clk, no_sync,
  output tvd_pkg::tvd_code_t r, g, b,
  output logic              sync_n, blank_n
);
  int   seed = 7004;
  logic bl;
  initial {r, g, b, sync_n, blank_n} = '0;
  always @(posedge clk) begin
    bl = ($random(seed) & 3) != 0;
    r <= 8'($random(seed));
    g <= 8'($random(seed));
    b <= 8'($random(seed));
    blank_n <= bl;
    sync_n <= !no_sync && (bl || $random(seed) % 2 == 0);
  end
endmodule // tvd_pix_src

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "tvd_params.svh"
module tb_top;
  import tvd_pkg::*;
  logic        clk = 0, rst = 0, ce = 1, out_ready = 1, no_sync = 0, chk_en = 0;
  logic        sync_n, blank_n, out_valid, sync_current_out, in_stall;
  tvd_code_t   r, g, b;
  tvd_level_t  red_current_out, green_current_out, blue_current_out;
  logic [31:0] e0, e1;
  int          n_mismatch = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  tvd_pix_src u_tvd_pix_src (.clk, .no_sync, .r, .g, .b, .sync_n, .blank_n);
  tvd_dac_front u_tvd_dac_front (.clk, .rst, .ce, .red_code_in(r), .green_code_in(g), .blue_code_in(b),
    .sync_n_in(sync_n), .blank_n_in(blank_n), .out_ready, .out_valid, .red_current_out,
    .green_current_out, .blue_current_out, .sync_current_out, .in_stall);
  function automatic tvd_level_t lv(tvd_code_t c, logic bk, logic s);
    return (bk ? `TVD_PEDESTAL + c : 10'h0) + (s ? `TVD_SYNC_STEP : 10'h0);
  endfunction
  // two-stage-late expectation, valid only while ready stays high
  always @(posedge clk) begin
    e0 <= {1'b1, lv(r, blank_n, 1'b0), lv(g, blank_n, sync_n), lv(b, blank_n, 1'b0), sync_n};
    e1 <= e0;
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge clk) if (chk_en) chk({out_valid, red_current_out, green_current_out, blue_current_out, sync_current_out}, e1);
  task automatic run(int n);
    repeat (2) @(posedge clk);
    chk_en <= 1;
    repeat (n) @(posedge clk);
    chk_en <= 0;
  endtask
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1 rst = 1;
    repeat (16) @(posedge clk);
    rst <= 0;
    run(200);
    out_ready <= 0;
    repeat (5) @(posedge clk);
    repeat (8) if (!in_stall) @(negedge clk);
    chk({31'h0, in_stall}, 32'h1);
    @(posedge clk);
    ce <= 0;
    repeat (4) @(posedge clk);
    ce <= 1;
    // random stalls: only the checker judges here
    repeat (60) @(posedge clk) out_ready <= 1'($random(u_tvd_pix_src.seed));
    out_ready <= 1;
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    no_sync <= 1;
    run(100);
    print_verdict;
  end
endmodule // tb_top
